// File: design/jt_pkg.sv
// Purpose : Shared constants and carriers for the boundary-scan test port
// Assumes : Six-bit instructions, 161 boundary cells, 32-bit identification
// Notes   : Pin counts split the 161 cells into inputs, outputs and bidirectionals
package jt_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Instruction codes
    localparam logic [5:0] IR_EXTEST  = 6'h00;
    localparam logic [5:0] IR_SAMPLE  = 6'h01;
    localparam logic [5:0] IR_CLAMP   = 6'h02;
    localparam logic [5:0] IR_HIGHZ   = 6'h05;
    localparam logic [5:0] IR_IDCODE  = 6'h20;
    localparam logic [5:0] IR_USRCODE = 6'h25;
    localparam logic [5:0] IR_BYPASS  = 6'h3f;
    localparam logic [5:0] IR_CAPTURE = 6'h01;  // Fixed pattern loaded at capture

    ////////////////////////////////////////////////////////////////////////////////
    // Boundary register layout
    localparam int N_IN   = 53;
    localparam int N_OUT  = 48;
    localparam int N_BI   = 20;
    localparam int N_BSR  = 161;
    localparam int C_IN   = 0;                 // Input cells
    localparam int C_OUT  = C_IN + N_IN;       // Output cells
    localparam int C_BIN  = C_OUT + N_OUT;     // Bidirectional input cells
    localparam int C_BOUT = C_BIN + N_BI;      // Bidirectional output cells
    localparam int C_BCTL = C_BOUT + N_BI;     // Bidirectional enable cells

    ////////////////////////////////////////////////////////////////////////////////
    // Identification fields; all values are arbitrary
    localparam logic [3:0]  ID_VER  = 4'h2;
    localparam logic [3:0]  USR_VER = 4'h3;
    localparam logic [15:0] ID_FAM  = 16'h1234;
    localparam logic [10:0] ID_MFR  = 11'h155;
    localparam logic [31:0] IDCODE_VAL  = {ID_VER, ID_FAM, ID_MFR, 1'b1};
    localparam logic [31:0] USRCODE_VAL = {USR_VER, ID_FAM, ID_MFR, 1'b1};

    ////////////////////////////////////////////////////////////////////////////////
    // Controller states, one-hot
    typedef enum logic [15:0] {
        TAP_TLR  = 16'h0001, TAP_RTI  = 16'h0002, TAP_SDRS = 16'h0004, TAP_CDR  = 16'h0008,
        TAP_SDR  = 16'h0010, TAP_E1DR = 16'h0020, TAP_PDR  = 16'h0040, TAP_E2DR = 16'h0080,
        TAP_UDR  = 16'h0100, TAP_SIRS = 16'h0200, TAP_CIR  = 16'h0400, TAP_SIR  = 16'h0800,
        TAP_E1IR = 16'h1000, TAP_PIR  = 16'h2000, TAP_E2IR = 16'h4000, TAP_UIR  = 16'h8000
    } jt_tap_e;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin carriers
    typedef struct packed {
        logic [N_OUT-1:0] out;
        logic [N_OUT-1:0] out_oe;
        logic [N_BI-1:0]  bi_out;
        logic [N_BI-1:0]  bi_oe;
    } jt_drv_s;

    typedef struct packed {
        logic [N_IN-1:0] in;
        logic [N_BI-1:0] bi_in;
    } jt_rcv_s;

endpackage : jt_pkg

// File: design/jt_tap.sv
// Purpose : Boundary-scan test access port with 161-cell boundary register
// Assumes : tck is the tester clock, clk the system clock, both unrelated
// Notes   : Pin drive and pin sampling for the core run on clk
//
// Overview of operation
// - Code 111111 selects one-stage bypass path
// - Code 000000 selects boundary cells, drives pins
// - Code 000101 floats outputs, selects bypass
// - Code 000001 snapshots pins, allows preload shifting
// - Code 100000 shifts out device identification
// - Code 100101 shifts out user identification
// - Undefined codes select the bypass stage
// - Every pin observed, every output drivable
// - Bidirectional pins use input, output, enable
// - Reset selects identification instruction by default
// - Undefined codes act as bypass
// - Low trst_n resets test logic asynchronously
`timescale 1ns/1ps
module jt_tap
    import jt_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            rst_n,
    input  wire logic            tck,
    input  wire logic            trst_n,
    input  wire logic            tms,
    input  wire logic            tdi,
    output logic                 tdo,
    output logic                 tdo_oe,
    input  wire jt_pkg::jt_drv_s core_drv,
    output jt_pkg::jt_drv_s      pad_drv,
    input  wire jt_pkg::jt_rcv_s pad_rcv,
    output jt_pkg::jt_rcv_s      core_rcv
);
    import jt_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Test clock domain state
    typedef struct packed {
        jt_tap_e          tap;
        logic [5:0]       ir_sh;
        logic [5:0]       ir;
        logic [N_BSR-1:0] bsr_sh;
        logic [N_BSR-1:0] bsr_upd;
        logic [31:0]      id_sh;
        logic             byp;
        logic             upd_tgl;
        logic             drive;
        logic             highz;
        jt_drv_s          core_s1;
        jt_drv_s          core_s2;
        jt_rcv_s          pad_s1;
        jt_rcv_s          pad_s2;
    } jt_tck_s;

    typedef struct packed {
        logic tdo;
        logic oe;
    } jt_neg_s;

    // System clock domain state
    typedef struct packed {
        logic [2:0]       tgl;
        logic [1:0]       drive;
        logic [1:0]       highz;
        logic [N_BSR-1:0] cells;
        jt_rcv_s          rcv_s1;
        jt_rcv_s          rcv_q;
        jt_drv_s          drv_q;
    } jt_clk_s;

    jt_tck_s t_q, t_d;
    jt_neg_s n_q, n_d;
    jt_clk_s c_q, c_d;

    logic             sel_bsr;
    logic             sel_id;
    logic             sel_usr;
    logic             sel_byp;
    logic [N_BSR-1:0] cap_vec;

    ////////////////////////////////////////////////////////////////////////////////
    // Controller next state
    function automatic jt_tap_e tap_next(input jt_tap_e s, input logic m);
        case (s)
            TAP_TLR:  tap_next = m ? TAP_TLR  : TAP_RTI;
            TAP_RTI:  tap_next = m ? TAP_SDRS : TAP_RTI;
            TAP_SDRS: tap_next = m ? TAP_SIRS : TAP_CDR;
            TAP_CDR:  tap_next = m ? TAP_E1DR : TAP_SDR;
            TAP_SDR:  tap_next = m ? TAP_E1DR : TAP_SDR;
            TAP_E1DR: tap_next = m ? TAP_UDR  : TAP_PDR;
            TAP_PDR:  tap_next = m ? TAP_E2DR : TAP_PDR;
            TAP_E2DR: tap_next = m ? TAP_UDR  : TAP_SDR;
            TAP_UDR:  tap_next = m ? TAP_SDRS : TAP_RTI;
            TAP_SIRS: tap_next = m ? TAP_TLR  : TAP_CIR;
            TAP_CIR:  tap_next = m ? TAP_E1IR : TAP_SIR;
            TAP_SIR:  tap_next = m ? TAP_E1IR : TAP_SIR;
            TAP_E1IR: tap_next = m ? TAP_UIR  : TAP_PIR;
            TAP_PIR:  tap_next = m ? TAP_E2IR : TAP_PIR;
            TAP_E2IR: tap_next = m ? TAP_UIR  : TAP_SIR;
            TAP_UIR:  tap_next = m ? TAP_SDRS : TAP_RTI;
            default:  tap_next = TAP_TLR;
        endcase
    endfunction : tap_next

    ////////////////////////////////////////////////////////////////////////////////
    // Instruction decode; anything undefined falls to bypass
    always_comb begin
        sel_bsr = (t_q.ir == IR_EXTEST) || (t_q.ir == IR_SAMPLE);
        sel_id  = (t_q.ir == IR_IDCODE);
        sel_usr = (t_q.ir == IR_USRCODE);
        sel_byp = !(sel_bsr || sel_id || sel_usr);
    end

    // Capture image: inputs, outputs, then bidirectional input, output, enable
    assign cap_vec = {t_q.core_s2.bi_oe, t_q.core_s2.bi_out, t_q.pad_s2.bi_in,
                      t_q.core_s2.out, t_q.pad_s2.in};

    ////////////////////////////////////////////////////////////////////////////////
    // Test clock domain next state
    always_comb begin
        t_d         = t_q;
        t_d.tap     = tap_next(t_q.tap, tms);
        t_d.core_s1 = core_drv;
        t_d.core_s2 = t_q.core_s1;
        t_d.pad_s1  = pad_rcv;
        t_d.pad_s2  = t_q.pad_s1;
        case (t_q.tap)
            TAP_TLR: begin
                t_d.ir = IR_IDCODE;
            end
            TAP_CIR: begin
                t_d.ir_sh = IR_CAPTURE;
            end
            TAP_SIR: begin
                t_d.ir_sh = {tdi, t_q.ir_sh[5:1]};
            end
            TAP_UIR: begin
                t_d.ir = t_q.ir_sh;
            end
            TAP_CDR: begin
                if (sel_bsr) begin
                    t_d.bsr_sh = cap_vec;
                end
                t_d.id_sh = sel_usr ? USRCODE_VAL : IDCODE_VAL;
                t_d.byp   = 1'b0;
            end
            TAP_SDR: begin
                if (sel_bsr) begin
                    t_d.bsr_sh = {tdi, t_q.bsr_sh[N_BSR-1:1]};
                end
                t_d.id_sh = {tdi, t_q.id_sh[31:1]};
                t_d.byp   = tdi;
            end
            TAP_UDR: begin
                if (sel_bsr) begin
                    t_d.bsr_upd = t_q.bsr_sh;
                    t_d.upd_tgl = !t_q.upd_tgl;
                end
            end
            default: begin
            end
        endcase
        t_d.drive = (t_d.ir == IR_EXTEST) || (t_d.ir == IR_CLAMP);
        t_d.highz = (t_d.ir == IR_HIGHZ);
    end

    // Test clock registers, cleared at once by trst_n
    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            t_q     <= '0;
            t_q.tap <= TAP_TLR;
            t_q.ir  <= IR_IDCODE;
        end else begin
            t_q <= t_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Serial output, changed on the falling edge
    always_comb begin
        n_d.oe = (t_q.tap == TAP_SIR) || (t_q.tap == TAP_SDR);
        if (t_q.tap == TAP_SIR) begin
            n_d.tdo = t_q.ir_sh[0];
        end else if (sel_bsr) begin
            n_d.tdo = t_q.bsr_sh[0];
        end else if (sel_id || sel_usr) begin
            n_d.tdo = t_q.id_sh[0];
        end else begin
            n_d.tdo = t_q.byp;
        end
    end

    always_ff @(negedge tck or negedge trst_n) begin
        if (!trst_n) begin
            n_q <= '0;
        end else begin
            n_q <= n_d;
        end
    end

    assign tdo    = n_q.tdo;
    assign tdo_oe = n_q.oe;

    ////////////////////////////////////////////////////////////////////////////////
    // System clock side: mode and cell word crossings, pin drive
    always_comb begin
        c_d        = c_q;
        c_d.tgl    = {c_q.tgl[1:0], t_q.upd_tgl};
        c_d.drive  = {c_q.drive[0], t_q.drive};
        c_d.highz  = {c_q.highz[0], t_q.highz};
        c_d.rcv_s1 = pad_rcv;
        c_d.rcv_q  = c_q.rcv_s1;
        if (c_q.tgl[2] != c_q.tgl[1]) begin
            c_d.cells = t_q.bsr_upd;                               // Stable since toggle
        end
        if (c_q.drive[1]) begin
            c_d.drv_q.out    = c_q.cells[C_OUT +: N_OUT];
            c_d.drv_q.out_oe = '1;
            c_d.drv_q.bi_out = c_q.cells[C_BOUT +: N_BI];
            c_d.drv_q.bi_oe  = c_q.cells[C_BCTL +: N_BI];
        end else begin
            c_d.drv_q = core_drv;
        end
        if (c_q.highz[1]) begin
            c_d.drv_q.out_oe = '0;
            c_d.drv_q.bi_oe  = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            c_q <= '0;
        end else begin
            c_q <= c_d;
        end
    end

    assign pad_drv  = c_q.drv_q;
    assign core_rcv = c_q.rcv_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks on the test clock
    sequence s_tms_high;
        tms [*5];
    endsequence

    property p_tlr_reach;
        @(posedge tck) disable iff (!trst_n) s_tms_high |=> (t_q.tap == TAP_TLR);
    endproperty
    a_tlr_reach: assert property (p_tlr_reach) else $error("five tms highs miss reset state");

    property p_default_ir;
        @(posedge tck) disable iff (!trst_n) (t_q.tap == TAP_TLR) |=> (t_q.ir == IR_IDCODE);
    endproperty
    a_default_ir: assert property (p_default_ir) else $error("reset state lost default code");

    property p_byp_stage;
        @(posedge tck) disable iff (!trst_n)
            (t_q.tap == TAP_SDR) && sel_byp |=> (t_q.byp == $past(tdi));
    endproperty
    a_byp_stage: assert property (p_byp_stage) else $error("bypass stage lost tdi");

    property p_reserved_byp;
        @(posedge tck) disable iff (!trst_n)
            (t_q.ir != IR_EXTEST) && (t_q.ir != IR_SAMPLE) && (t_q.ir != IR_IDCODE)
            && (t_q.ir != IR_USRCODE) && (t_q.ir != IR_CLAMP) && (t_q.ir != IR_HIGHZ)
            |-> sel_byp && !t_q.drive && !t_q.highz;
    endproperty
    a_reserved_byp: assert property (p_reserved_byp) else $error("code did not fall to bypass");

    // Serial output shows the identification bit while shifting
    property p_tdo_id;
        @(posedge tck) disable iff (!trst_n)
            (t_q.tap == TAP_SDR) && sel_id |-> tdo_oe && (tdo == t_q.id_sh[0]);
    endproperty
    a_tdo_id: assert property (p_tdo_id) else $error("identification bit not on tdo");

    property p_idcode;
        @(posedge tck) disable iff (!trst_n)
            (t_q.tap == TAP_CDR) && sel_id |=> (t_q.id_sh == IDCODE_VAL) && t_q.id_sh[0];
    endproperty
    a_idcode: assert property (p_idcode) else $error("identification capture wrong");

    property p_usrcode;
        @(posedge tck) disable iff (!trst_n)
            (t_q.tap == TAP_CDR) && sel_usr |=> (t_q.id_sh == USRCODE_VAL) && t_q.id_sh[0];
    endproperty
    a_usrcode: assert property (p_usrcode) else $error("user identification capture wrong");

    property p_bsr_cap;
        @(posedge tck) disable iff (!trst_n)
            (t_q.tap == TAP_CDR) && sel_bsr |=> (t_q.bsr_sh == $past(cap_vec));
    endproperty
    a_bsr_cap: assert property (p_bsr_cap) else $error("boundary capture wrong");

    // Checks on the system clock
    property p_highz;
        @(posedge clk) disable iff (!rst_n)
            c_q.highz[1] |=> (pad_drv.out_oe == '0) && (pad_drv.bi_oe == '0);
    endproperty
    a_highz: assert property (p_highz) else $error("outputs not floated");

    property p_hold;
        @(posedge clk) disable iff (!rst_n)
            c_q.drive[1] && !c_q.highz[1] && (c_q.tgl[2] == c_q.tgl[1]) ##1
            c_q.drive[1] && !c_q.highz[1] && (c_q.tgl[2] == c_q.tgl[1]) |=> $stable(pad_drv);
    endproperty
    a_hold: assert property (p_hold) else $error("held pins changed");

    property p_bi_ctl;
        @(posedge clk) disable iff (!rst_n)
            c_q.drive[1] && !c_q.highz[1] |=> (pad_drv.bi_oe == $past(c_q.cells[C_BCTL +: N_BI]));
    endproperty
    a_bi_ctl: assert property (p_bi_ctl) else $error("enable cell not applied");

endmodule : jt_tap

// File: verif/jt_tester.sv
// Purpose : Tester model that drives the boundary-scan port
// Assumes : Test clock period 30 ns, held low between frames
// Notes   : tms and tdi change after the falling edge, tdo is read at the rise
`timescale 1ns/1ps
module jt_tester (
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    // Idle levels before the first frame
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One test clock period; tdo is taken at the rising edge
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #15 tck = 1'b1;
        q = tdo;
        #15 tck = 1'b0;
    endtask : step

    // Five ones reach Test-Logic-Reset, a zero moves on to Run-Test/Idle
    task automatic reset_walk();
        logic q;
        repeat (5) step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
    endtask : reset_walk

    // Shift n bits LSB first from Run-Test/Idle, update, and return to idle
    task automatic scan(input bit ir, input int n, input logic [160:0] din,
                        output logic [160:0] dout);
        logic q;
        dout = '0;
        step(1'b1, 1'b0, q);
        if (ir) begin
            step(1'b1, 1'b0, q);
        end
        step(1'b0, 1'b0, q);
        step(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
        tdi = ~tdi; // Released line does not keep its last value
    endtask : scan
endmodule : jt_tester

// File: verif/jt_tap_tb_top.sv
// Purpose : Self-checking bench for the boundary-scan test port
// Assumes : jt_tester model drives tck, tms and tdi
// Notes   : Pin-side inputs change on the falling edge of clk
`timescale 1ns/1ps
module jt_tap_tb_top;
    import jt_pkg::*;
    logic         clk, rst_n, trst_n, tck, tms, tdi, tdo, tdo_oe, q;
    jt_drv_s      core_drv, pad_drv;
    jt_rcv_s      pad_rcv, core_rcv;
    int           n_fail, num_checks;
    logic [160:0] cap, o;

    jt_tap i_jt_tap (.clk(clk), .rst_n(rst_n), .tck(tck), .trst_n(trst_n), .tms(tms),
        .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .core_drv(core_drv), .pad_drv(pad_drv),
        .pad_rcv(pad_rcv), .core_rcv(core_rcv));
    jt_tester i_jt_tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

    // System clock
    always #2 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic chk(input string nm, input logic [160:0] e, input logic [160:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic ir(input logic [5:0] c);
        i_jt_tester.scan(1'b1, 6, {155'h0, c}, o);
    endtask : ir

    task automatic dr(input int n, input logic [160:0] d);
        i_jt_tester.scan(1'b0, n, d, o);
    endtask : dr

    // Bounded wait for the pads to settle on a masked value
    task automatic wait_pad(input logic [135:0] e, input logic [135:0] m, input string nm);
        for (int i = 0; i < 40 && ((pad_drv ^ e) & m) != '0; i++) @(negedge clk);
        chk(nm, e & m, pad_drv & m);
        if (((pad_drv ^ e) & m) != '0) begin
            summarize(); // Bound used up
        end
    endtask : wait_pad

    task automatic summarize();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_id();
        dr(32, '0);
        chk("idcode", IDCODE_VAL, o);
        ir(IR_USRCODE);
        chk("ir_capture", 6'h01, o);
        dr(32, '0);
        chk("usercode", USRCODE_VAL, o);
    endtask : t_id

    task automatic t_byp(input logic [5:0] c);
        ir(c);
        dr(9, 9'h1a5);
        chk("bypass", 9'h14a, o);
    endtask : t_byp

    task automatic t_sample();
        ir(IR_SAMPLE);
        dr(161, ~cap);
        chk("sample_cap", cap, o);
        chk("sample_pads", core_drv, pad_drv);
        chk("core_rcv", pad_rcv, core_rcv);
    endtask : t_sample

    task automatic t_ext();
        logic [160:0] x;
        x = ~cap;
        ir(IR_EXTEST);
        wait_pad({x[100:53], {48{1'b1}}, x[140:121], x[160:141]}, '1, "ext_pre");
        dr(161, cap);
        chk("ext_in", pad_rcv.in, o[52:0]);
        wait_pad({cap[100:53], {48{1'b1}}, cap[140:121], cap[160:141]}, '1, "ext_upd");
    endtask : t_ext

    task automatic t_clamp();
        t_byp(IR_CLAMP);
        @(negedge clk) core_drv = ~core_drv;
        repeat (10) @(negedge clk);
        chk("clamp_hold", {cap[100:53], {48{1'b1}}, cap[140:121], cap[160:141]}, pad_drv);
    endtask : t_clamp

    task automatic t_trst();
        i_jt_tester.step(1'b1, 1'b0, q);
        i_jt_tester.step(1'b0, 1'b0, q);
        i_jt_tester.step(1'b0, 1'b0, q);
        #1 chk("oe_shift", 1'b1, tdo_oe);
        @(negedge clk) trst_n = 1'b0;
        #10 chk("oe_reset", 1'b0, tdo_oe);
        @(negedge clk) trst_n = 1'b1;
        i_jt_tester.step(1'b0, 1'b0, q);
        dr(32, '0);
        chk("id_after_reset", IDCODE_VAL, o);
        wait_pad(core_drv, '1, "normal_again");
    endtask : t_trst

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence and watchdog
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        trst_n = 1'b0;
        n_fail = 0;
        num_checks = 0;
        core_drv = {48'ha5a5_0f0f_3c3c, 48'hffff_0000_ffff, 20'h5a5a5, 20'hf0f0f};
        pad_rcv = {53'h1f_0123_4567_89ab, 20'h3c3c3};
        cap = {core_drv.bi_oe, core_drv.bi_out, pad_rcv.bi_in, core_drv.out, pad_rcv.in};
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        trst_n = 1'b1;
        wait_pad(core_drv, '1, "normal");
        i_jt_tester.reset_walk();
        t_id();
        t_byp(IR_BYPASS);
        t_byp(6'h3e);
        t_byp(6'h11);
        t_sample();
        t_ext();
        t_clamp();
        t_byp(IR_HIGHZ);
        wait_pad('0, {48'h0, {48{1'b1}}, 20'h0, 20'hfffff}, "highz");
        t_trst();
        summarize();
    end

    initial begin
        #300000;
        n_fail++;
        $display("CHECK FAILED watchdog expected done seen running");
        summarize();
    end
endmodule : jt_tap_tb_top
